// ---- sram_bus_assertions.sv ----
// Concurrent checks on the SRAM bus between host and core ends
`timescale 1ns/10ps
module sram_bus_assertions (
  input wire logic                            clock_i,
  input wire logic                            reset_i,
  input wire logic                            clock_qualify_n,
  input wire logic                            chip_select_a_n,
  input wire logic                            chip_select_b,
  input wire logic                            chip_select_c_n,
  input wire logic                            write_n,
  input wire logic                            advance_or_load,
  input wire logic                            output_enable_n,
  input wire logic                            sleep_request,
  input wire logic [sram_bus_pkg::DATA_W-1:0] mem_dq_o,
  input wire logic                            mem_dq_oe,
  input wire logic                            host_dq_oe
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  logic sel, go, rd_ld, wr_ld, desel;
  assign sel   = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign go    = !clock_qualify_n && !sleep_request;
  assign rd_ld = go && !advance_or_load && sel && write_n;
  assign wr_ld = go && !advance_or_load && sel && !write_n;
  assign desel = go && !advance_or_load && !sel;
  // Second read of a pair is clear of the first-cycle masking after deselect
  sequence s_rd_pair; rd_ld ##1 rd_ld ##1 go; endsequence
  sequence s_wr_go; wr_ld ##1 go; endsequence
  sequence s_stall;
    (clock_qualify_n && !sleep_request) ##1 (!sleep_request && $stable(output_enable_n));
  endsequence
  a_read_drives: assert property (s_rd_pair |-> ##1 (output_enable_n || mem_dq_oe))
    else $error("read data not driven");
  a_first_after_desel: assert property (desel ##1 rd_ld |-> ##1 !mem_dq_oe)
    else $error("output driven right after deselect");
  a_desel_off: assert property (desel ##1 go |-> ##1 !mem_dq_oe)
    else $error("output driven after deselect");
  a_write_off: assert property (s_wr_go |-> ##1 !mem_dq_oe)
    else $error("output driven in write data phase");
  a_write_data_phase: assert property (s_wr_go |-> ##1 host_dq_oe)
    else $error("host not driving write data");
  a_oe_async: assert property (output_enable_n |-> !mem_dq_oe)
    else $error("output driven with enable high");
  a_no_contend: assert property (!(mem_dq_oe && host_dq_oe))
    else $error("both ends drive data");
  a_reset_quiet: assert property ($fell(reset_i) |-> !mem_dq_oe ##1 !mem_dq_oe)
    else $error("output driven after reset");
  a_sleep_off: assert property (sleep_request [*3] |-> !mem_dq_oe)
    else $error("output driven in sleep");
  a_stall_keeps: assert property (s_stall |-> $stable(mem_dq_oe) &&
                                  (!mem_dq_oe || $stable(mem_dq_o)))
    else $error("output changed on stalled edge");
endmodule

// ---- sram_bus_if.sv ----
// Synchronous SRAM bus between memory controller and SRAM core
`timescale 1ns/10ps
interface sram_bus_if;
  logic [sram_bus_pkg::ADDR_W-1:0] addr;
  logic                            clock_qualify_n;
  logic                            chip_select_a_n;
  logic                            chip_select_b;
  logic                            chip_select_c_n;
  logic                            write_n;
  logic                            advance_or_load;
  logic [sram_bus_pkg::LANES-1:0]  byte_lane_write_n;
  logic                            output_enable_n;
  logic                            burst_interleaved;
  logic                            sleep_request;
  logic [sram_bus_pkg::DATA_W-1:0] mem_dq_o;
  logic                            mem_dq_oe;
  logic [sram_bus_pkg::DATA_W-1:0] host_dq_o;
  logic                            host_dq_oe;
  logic [sram_bus_pkg::DATA_W-1:0] dq;
  // Undriven bus reads back inverted so a missing drive cannot pass for data
  assign dq = mem_dq_oe  ? mem_dq_o  :
              host_dq_oe ? host_dq_o : ~mem_dq_o;
  modport mem (input addr, clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n,
               write_n, advance_or_load, byte_lane_write_n, output_enable_n,
               burst_interleaved, sleep_request, dq, output mem_dq_o, mem_dq_oe);
  modport host (output addr, clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n,
                write_n, advance_or_load, byte_lane_write_n, output_enable_n,
                burst_interleaved, sleep_request, host_dq_o, host_dq_oe, input dq);
endinterface

// ---- sram_bus_pkg.sv ----
// Shared constants for the pipelined burst SRAM link
package sram_bus_pkg;
  localparam int ADDR_W       = 17;
  localparam int LANES        = 4;
  localparam int LANE_W       = 9;
  localparam int DATA_W       = LANES * LANE_W;
  localparam int BURST_LEN    = 4;
  localparam int SLEEP_CYCLES = 2;
  localparam int CLK_PERIOD_NS = 25;
  // Sleep recovery time expressed in clock periods, then cycles
  localparam int SLEEP_RECOVERY_PERIODS = 2;
  localparam int SLEEP_RECOVERY_CYCLES  = SLEEP_RECOVERY_PERIODS * CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] SLEEP_CNT_ZERO = 2'h0;
  localparam logic [1:0] SLEEP_CNT_FULL = 2'h2;
endpackage

// ---- sram_core.sv ----
// SRAM device end: pipelined burst memory with byte-lane writes and sleep
`timescale 1ns/10ps
module sram_core #(
  parameter int DEPTH = 1 << sram_bus_pkg::ADDR_W
) (
  input  wire logic   clock_i,
  input  wire logic   reset_i,
  sram_bus_if.mem     bus,
  output logic        asleep_o
);
  localparam int AW = sram_bus_pkg::ADDR_W;
  localparam int DW = sram_bus_pkg::DATA_W;
  localparam int LW = sram_bus_pkg::LANE_W;

  logic [DW-1:0] mem_array [DEPTH];

  // Pipeline stage 1: captured operation
  logic          s1_valid_q, s1_valid_d;
  logic          s1_write_q, s1_write_d;
  logic [AW-1:0] s1_addr_q,  s1_addr_d;
  logic [1:0]    base_q,     base_d;
  logic [1:0]    count_q,    count_d;
  logic          burst_q,    burst_d;
  logic          dir_write_q, dir_write_d;
  logic          active_q,   active_d;
  // Pipeline stage 2: data phase
  logic          s2_valid_q, s2_valid_d;
  logic          s2_write_q, s2_write_d;
  logic [AW-1:0] s2_addr_q,  s2_addr_d;
  logic [DW-1:0] rd_data_q,  rd_data_d;
  logic          fresh_q,    fresh_d;
  logic [1:0]    sleep_cnt_q, sleep_cnt_d;

  function automatic logic [1:0] burst_low(input logic [1:0] base, input logic [1:0] cnt,
                                           input logic inter);
    burst_low = inter ? (base ^ cnt) : 2'(base + cnt);
  endfunction

  logic selected;
  logic sleeping;
  logic stall;
  assign selected = !bus.chip_select_a_n && bus.chip_select_b && !bus.chip_select_c_n;
  assign sleeping = (sleep_cnt_q == sram_bus_pkg::SLEEP_CNT_FULL);
  assign stall    = bus.clock_qualify_n;

  always_comb begin
    logic [1:0] nxt;
    nxt         = 2'(count_q + sram_bus_pkg::BURST_STEP);
    s1_valid_d  = s1_valid_q;
    s1_write_d  = s1_write_q;
    s1_addr_d   = s1_addr_q;
    base_d      = base_q;
    count_d     = count_q;
    burst_d     = burst_q;
    dir_write_d = dir_write_q;
    active_d    = active_q;
    s2_valid_d  = s2_valid_q;
    s2_write_d  = s2_write_q;
    s2_addr_d   = s2_addr_q;
    fresh_d     = fresh_q;
    sleep_cnt_d = sleep_cnt_q;
    // Sleep sequencing counts both ways; entry takes two cycles, but sleeping clears one cycle into exit
    if (bus.sleep_request && sleep_cnt_q != sram_bus_pkg::SLEEP_CNT_FULL) begin
      sleep_cnt_d = 2'(sleep_cnt_q + sram_bus_pkg::BURST_STEP);
    end else if (!bus.sleep_request && sleep_cnt_q != sram_bus_pkg::SLEEP_CNT_ZERO) begin
      sleep_cnt_d = 2'(sleep_cnt_q - sram_bus_pkg::BURST_STEP);
    end
    if (bus.sleep_request || sleeping) begin
      s1_valid_d = 1'b0;
      s2_valid_d = 1'b0;
      burst_d    = 1'b0;
      active_d   = 1'b0;
    end else if (!stall) begin
      s2_valid_d = s1_valid_q;
      s2_write_d = s1_write_q;
      s2_addr_d  = s1_addr_q;
      fresh_d    = !active_q;
      if (bus.advance_or_load) begin
        s1_valid_d = burst_q;
        s1_write_d = dir_write_q;
        count_d    = nxt;
        s1_addr_d  = {s1_addr_q[AW-1:2],
                      burst_low(base_q, nxt, bus.burst_interleaved)};
        active_d   = burst_q;
      end else if (selected) begin
        s1_valid_d  = 1'b1;
        s1_write_d  = !bus.write_n;
        dir_write_d = !bus.write_n;
        s1_addr_d   = bus.addr;
        base_d      = bus.addr[1:0];
        count_d     = 2'h0;
        burst_d     = 1'b1;
        active_d    = 1'b1;
      end else begin
        s1_valid_d = 1'b0;
        burst_d    = 1'b0;
        active_d   = 1'b0;
      end
    end
  end

  // Read data captured in the output register in the same phase writes land
  always_comb begin
    rd_data_d = rd_data_q;
    if (!stall && s1_valid_q && !s1_write_q && !sleeping) begin
      rd_data_d = mem_array[s1_addr_q];
      // A write landing on this edge to the same word is passed through, else it reads stale
      if (s2_valid_q && s2_write_q && !bus.sleep_request && s2_addr_q == s1_addr_q) begin
        for (int l = 0; l < sram_bus_pkg::LANES; l++) begin
          if (!bus.byte_lane_write_n[l]) begin
            rd_data_d[l*LW +: LW] = bus.dq[l*LW +: LW];
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      s1_valid_q  <= 1'b0;
      s1_write_q  <= 1'b0;
      s1_addr_q   <= '0;
      base_q      <= 2'h0;
      count_q     <= 2'h0;
      burst_q     <= 1'b0;
      dir_write_q <= 1'b0;
      active_q    <= 1'b0;
      s2_valid_q  <= 1'b0;
      s2_write_q  <= 1'b0;
      s2_addr_q   <= '0;
      rd_data_q   <= '0;
      fresh_q     <= 1'b1;
      sleep_cnt_q <= sram_bus_pkg::SLEEP_CNT_ZERO;
    end else begin
      s1_valid_q  <= s1_valid_d;
      s1_write_q  <= s1_write_d;
      s1_addr_q   <= s1_addr_d;
      base_q      <= base_d;
      count_q     <= count_d;
      burst_q     <= burst_d;
      dir_write_q <= dir_write_d;
      active_q    <= active_d;
      s2_valid_q  <= s2_valid_d;
      s2_write_q  <= s2_write_d;
      s2_addr_q   <= s2_addr_d;
      rd_data_q   <= rd_data_d;
      fresh_q     <= fresh_d;
      sleep_cnt_q <= sleep_cnt_d;
    end
  end

  // Array has no reset; contents survive sleep
  always_ff @(posedge clock_i) begin
    if (!stall && s2_valid_q && s2_write_q && !bus.sleep_request && !sleeping) begin
      for (int l = 0; l < sram_bus_pkg::LANES; l++) begin
        if (!bus.byte_lane_write_n[l]) begin
          mem_array[s2_addr_q][l*LW +: LW] <= bus.dq[l*LW +: LW];
        end
      end
    end
  end

  // Output enable gates combinationally; writes and deselects mask it
  assign bus.mem_dq_o  = rd_data_q;
  assign bus.mem_dq_oe = s2_valid_q && !s2_write_q && !bus.output_enable_n
                         && !fresh_q && !sleeping;
  assign asleep_o      = sleeping;
endmodule

// ---- sram_host.sv ----
// Host controller end: issues single and burst reads and writes
`timescale 1ns/10ps
module sram_host (
  input  wire logic                              clock_i,
  input  wire logic                              reset_i,
  sram_bus_if.host                               bus,
  input  wire logic                              req_valid_i,
  input  wire logic                              req_write_i,
  input  wire logic                              req_burst_i,
  input  wire logic [sram_bus_pkg::ADDR_W-1:0]   req_addr_i,
  input  wire logic [sram_bus_pkg::DATA_W-1:0]   req_wdata_i,
  input  wire logic [sram_bus_pkg::LANES-1:0]    req_lanes_i,
  input  wire logic                              stall_i,
  input  wire logic                              sleep_i,
  input  wire logic                              interleaved_i,
  output logic                                   req_ready_o,
  output logic                                   rd_valid_o,
  output logic [sram_bus_pkg::DATA_W-1:0]        rd_data_o
);
  logic          rd1_q, rd1_d, rd2_q, rd2_d;
  logic          wr1_q, wr1_d, wr2_q, wr2_d;
  logic [sram_bus_pkg::DATA_W-1:0] wd1_q, wd1_d, wd2_q, wd2_d;
  logic [sram_bus_pkg::LANES-1:0]  ln1_q, ln1_d, ln2_q, ln2_d;
  logic          in_burst_q, in_burst_d;
  logic [1:0]    rec_q, rec_d;
  logic          rd_valid_q, rd_valid_d;
  logic [sram_bus_pkg::DATA_W-1:0] rd_data_q, rd_data_d;
  logic          issue;

  // Recovery window blocks selects after sleep
  assign req_ready_o = !sleep_i && rec_q == sram_bus_pkg::SLEEP_CNT_ZERO && !stall_i;
  assign issue       = req_valid_i && req_ready_o;

  assign bus.clock_qualify_n   = stall_i;
  assign bus.sleep_request     = sleep_i;
  assign bus.burst_interleaved = interleaved_i;
  assign bus.addr              = req_addr_i;
  assign bus.write_n           = !req_write_i;
  assign bus.advance_or_load   = issue && req_burst_i && in_burst_q;
  assign bus.chip_select_a_n   = !issue;
  assign bus.chip_select_b     = issue;
  assign bus.chip_select_c_n   = !issue;
  // Lane selects follow the word whose data lands this edge
  assign bus.byte_lane_write_n = wr2_q ? ~ln2_q : '1;
  // Output enable raised only while write data is driven; earlier would mask a read
  assign bus.output_enable_n   = wr2_q;
  assign bus.host_dq_o         = wd2_q;
  assign bus.host_dq_oe        = wr2_q;

  always_comb begin
    rd1_d = rd1_q; rd2_d = rd2_q; wr1_d = wr1_q; wr2_d = wr2_q;
    wd1_d = wd1_q; wd2_d = wd2_q; ln1_d = ln1_q; ln2_d = ln2_q;
    in_burst_d = in_burst_q;
    rd_valid_d = 1'b0;
    rd_data_d  = rd_data_q;
    rec_d = rec_q;
    if (sleep_i) begin
      rec_d = 2'(sram_bus_pkg::SLEEP_RECOVERY_CYCLES);
      rd1_d = 1'b0; rd2_d = 1'b0; wr1_d = 1'b0; wr2_d = 1'b0;
      in_burst_d = 1'b0;
    end else begin
      if (rec_q != sram_bus_pkg::SLEEP_CNT_ZERO) begin
        rec_d = 2'(rec_q - sram_bus_pkg::BURST_STEP);
      end
      if (!stall_i) begin
        rd2_d = rd1_q; wr2_d = wr1_q; wd2_d = wd1_q; ln2_d = ln1_q;
        rd1_d = issue && !req_write_i;
        wr1_d = issue && req_write_i;
        wd1_d = req_wdata_i;
        ln1_d = req_lanes_i;
        in_burst_d = issue;
        if (rd2_q) begin
          rd_valid_d = 1'b1;
          rd_data_d  = bus.dq;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rd1_q <= 1'b0; rd2_q <= 1'b0; wr1_q <= 1'b0; wr2_q <= 1'b0;
      wd1_q <= '0; wd2_q <= '0; ln1_q <= '0; ln2_q <= '0;
      in_burst_q <= 1'b0;
      rec_q      <= sram_bus_pkg::SLEEP_CNT_ZERO;
      rd_valid_q <= 1'b0;
      rd_data_q  <= '0;
    end else begin
      rd1_q <= rd1_d; rd2_q <= rd2_d; wr1_q <= wr1_d; wr2_q <= wr2_d;
      wd1_q <= wd1_d; wd2_q <= wd2_d; ln1_q <= ln1_d; ln2_q <= ln2_d;
      in_burst_q <= in_burst_d;
      rec_q      <= rec_d;
      rd_valid_q <= rd_valid_d;
      rd_data_q  <= rd_data_d;
    end
  end

  assign rd_valid_o = rd_valid_q;
  assign rd_data_o  = rd_data_q;
endmodule

// ---- test_pipelined_burst_sram_core.sv ----
// Self-checking bench joining host and core ends of the SRAM bus
`timescale 1ns/10ps
module test_pipelined_burst_sram_core;
  localparam int DW = sram_bus_pkg::DATA_W;
  localparam int AW = sram_bus_pkg::ADDR_W;
  logic          clock_i = 1'b0;
  logic          reset_i = 1'b1;
  logic          valid = 1'b0, wr = 1'b0, burst = 1'b0, stall = 1'b0;
  logic          sleep = 1'b0, inter = 1'b0, stall_on = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic [3:0]    lanes = 4'hF;
  logic          ready, rd_valid, asleep;
  logic [DW-1:0] rd_data;
  logic [DW-1:0] mem_m [int];
  logic [DW-1:0] exp_q [$];
  logic [AW-1:0] base;
  int            errors = 0;
  int            n_tests = 0;
  sram_bus_if bus ();
  always #12.5 clock_i = ~clock_i;
  sram_core u_sram_core (.clock_i(clock_i), .reset_i(reset_i), .bus(bus.mem), .asleep_o(asleep));
  sram_host u_sram_host (.clock_i(clock_i), .reset_i(reset_i), .bus(bus.host),
    .req_valid_i(valid), .req_write_i(wr), .req_burst_i(burst), .req_addr_i(addr),
    .req_wdata_i(wdata), .req_lanes_i(lanes), .stall_i(stall), .sleep_i(sleep),
    .interleaved_i(inter), .req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
  sram_bus_assertions u_sram_bus_assertions (.clock_i(clock_i), .reset_i(reset_i),
    .clock_qualify_n(bus.clock_qualify_n), .chip_select_a_n(bus.chip_select_a_n),
    .chip_select_b(bus.chip_select_b), .chip_select_c_n(bus.chip_select_c_n),
    .write_n(bus.write_n), .advance_or_load(bus.advance_or_load),
    .output_enable_n(bus.output_enable_n), .sleep_request(bus.sleep_request),
    .mem_dq_o(bus.mem_dq_o), .mem_dq_oe(bus.mem_dq_oe), .host_dq_oe(bus.host_dq_oe));
  task automatic chk_word(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [AW-1:0] step(input logic [AW-1:0] a, input int k, input logic il);
    logic [1:0] s;
    s = il ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
    return {a[AW-1:2], s};
  endfunction
  // Request held from a falling edge until the rising edge that takes it
  task automatic req(input logic w, input logic b, input logic [AW-1:0] a, input logic [3:0] l);
    int n;
    @(negedge clock_i);
    valid = 1'b1;
    wr = w;
    burst = b;
    addr = a;
    lanes = l;
    wdata = DW'({$urandom(), $urandom()});
    n = 0;
    @(posedge clock_i);
    while (ready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clock_i);
    end
    chk_bit("request taken", 1'b1, ready);
    if (w) begin
      for (int i = 0; i < 4; i++) if (l[i]) mem_m[a][9*i+:9] = wdata[9*i+:9];
    end else exp_q.push_back(mem_m[a]);
  endtask
  task automatic done(input string name);
    @(negedge clock_i);
    valid = 1'b0;
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge clock_i);
    chk_bit("reads drained", 1'b1, exp_q.size() == 0);
    exp_q.delete();
    $display("test %s finished", name);
  endtask
  // Reads scored in order of issue, so no fixed latency is assumed here
  always @(negedge clock_i) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk_word("spare read", 'x, rd_data);
      else chk_word("read data", exp_q.pop_front(), rd_data);
    end
    stall <= stall_on && ($urandom_range(0, 3) == 0);
  end
  initial begin
    #(25 * 20000);
    errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hAEC2E30C));
    base = AW'($urandom()) & 17'h1FF00;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    reset_i = 1'b0;
    for (int i = 0; i < 8; i++) req(1'b1, 1'b0, base + AW'(i), 4'hF);
    for (int i = 0; i < 8; i++) req(1'b0, 1'b0, base + AW'(i), 4'h0);
    for (int i = 0; i < 8; i++) begin
      req(1'b1, 1'b0, base + AW'(8 + i), 4'hF);
      req(1'b0, 1'b0, base + AW'(i), 4'h0);
    end
    req(1'b1, 1'b0, base + AW'(8), 4'h5);
    req(1'b0, 1'b0, base + AW'(8), 4'h0);
    done("single");
    // Full fill first so partial writes merge into known words
    for (int l = 0; l < 16; l++) req(1'b1, 1'b0, base + AW'(32 + l), 4'hF);
    for (int l = 0; l < 16; l++) req(1'b1, 1'b0, base + AW'(32 + l), 4'(l));
    for (int l = 0; l < 16; l++) req(1'b0, 1'b0, base + AW'(32 + l), 4'h0);
    done("lanes");
    for (int m = 0; m < 2; m++) begin
      done("idle");
      inter = m[0];
      for (int s = 0; s < 4; s++) begin
        for (int k = 0; k < 4; k++) req(1'b0, k > 0, step(base + AW'(s), k, inter), 4'h0);
      end
      for (int k = 0; k < 4; k++) req(1'b1, k > 0, step(base + AW'(2), k, inter), 4'(k + 1));
      for (int i = 0; i < 4; i++) req(1'b0, 1'b0, base + AW'(i), 4'h0);
    end
    done("burst");
    stall_on = 1'b1;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 4; k++) req(1'b0, k > 0, step(base + AW'(s), k, inter), 4'h0);
      req(1'b1, 1'b0, base + AW'(s), 4'hF);
    end
    done("stall");
    stall_on = 1'b0;
    done("idle");
    sleep = 1'b1;
    repeat (3) @(negedge clock_i);
    chk_bit("asleep", 1'b1, asleep);
    chk_bit("ready in sleep", 1'b0, ready);
    sleep = 1'b0;
    repeat (3) @(negedge clock_i);
    chk_bit("awake", 1'b0, asleep);
    for (int i = 0; i < 4; i++) req(1'b0, 1'b0, base + AW'(i), 4'h0);
    done("sleep");
    stop_test();
  end
endmodule
